// File: shared/mes_pkg.sv
package mes_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   // Software register byte addresses
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h4;
   localparam logic [3:0] REG_WDATA  = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam logic [3:0] REG_RDATA  = 4'h0;
   // Control fields
   localparam int CTRL_CMD_LSB = 0;
   localparam int CTRL_ACC_BIT = 4;
   localparam int CTRL_RST_BIT = 5;
   // Commands written to the control register
   localparam logic [3:0] CMD_READ    = 4'h1;
   localparam logic [3:0] CMD_PROGRAM = 4'h2;
   localparam logic [3:0] CMD_ERASE   = 4'h3;
   localparam logic [3:0] CMD_ID      = 4'h4;
   localparam logic [3:0] CMD_RESET   = 4'h5;
   // Device command codes
   localparam logic [15:0] UNLOCK_A1 = 16'h0555;
   localparam logic [15:0] UNLOCK_A2 = 16'h02aa;
   localparam logic [7:0]  UNLOCK_D1 = 8'haa;
   localparam logic [7:0]  UNLOCK_D2 = 8'h55;
   localparam logic [7:0]  CODE_ESET = 8'h80;
   localparam logic [7:0]  CODE_ERAS = 8'h10;
   localparam logic [7:0]  CODE_PROG = 8'ha0;
   localparam logic [7:0]  CODE_ID   = 8'h90;
   localparam logic [7:0]  CODE_RST  = 8'hf0;
   localparam int POLL_BIT = 7;
   localparam int TOGL_BIT = 6;
   localparam int TLIM_BIT = 5;
   // Strobe phase timing at 25 MHz: each phase at least 120 ns
   localparam int CLK_NS   = 40;
   localparam int PHASE_NS = 120;
   localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   // Status field offsets in the status register
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;

   typedef struct packed {
      logic                rd;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } mes_cyc_t;

   typedef struct packed {
      logic              ce_n;
      logic              we_n;
      logic              oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_o;
      logic              dq_oe;
   } mes_pins_t;
endpackage

// File: hw/mes_bus_cycle.sv
module mes_bus_cycle (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 start,
   input  mes_pkg::mes_cyc_t         req,
   input  wire logic [15:0]          dq_i,
   output mes_pkg::mes_pins_t        pins,
   output logic                      done,
   output logic [15:0]               rdata
);
   import mes_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} mes_bstate_t;

   mes_bstate_t       st_q;
   logic [2:0]        cnt_q;
   mes_cyc_t          cur_q;
   logic [15:0]       rdata_q;
   logic              done_q;
   wire               tick = (cnt_q == 3'(PHASE_CYC - 1));

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q    <= S_IDLE;
         cnt_q   <= 3'h0;
         cur_q   <= '0;
         rdata_q <= 16'h0000;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         cnt_q  <= (st_q == S_IDLE || tick) ? 3'h0 : cnt_q + 3'h1;
         unique case (st_q)
            S_IDLE: begin
               if (start) begin
                  cur_q <= req;
                  st_q  <= S_SETUP;
               end
            end
            S_SETUP: if (tick) st_q <= S_STROBE;
            S_STROBE: begin
               if (tick) begin
                  // Data sampled while output strobe still low
                  if (cur_q.rd) rdata_q <= dq_i;
                  st_q <= S_HOLD;
               end
            end
            S_HOLD: begin
               if (tick) begin
                  done_q <= 1'b1;
                  st_q   <= S_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Chip select falls one setup phase before the strobe; both rise together
   wire act = (st_q == S_STROBE);
   assign pins.ce_n  = ~(act || st_q == S_SETUP);
   assign pins.we_n  = ~(act && !cur_q.rd);
   assign pins.oe_n  = ~(act && cur_q.rd);
   assign pins.addr  = cur_q.addr;
   assign pins.dq_o  = cur_q.data;
   assign pins.dq_oe = (st_q != S_IDLE) && !cur_q.rd;
   assign done       = done_q;
   assign rdata      = rdata_q;
endmodule

// File: hw/mes_host.sv
// Local design decisions: the address map and the Wishbone interface to the registers.
module mes_host (
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   input  wire logic [3:0]                 wb_adr_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   input  wire logic                       wb_we_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   output logic                            wb_ack_o,
   output logic                            mem_ce_n,
   output logic                            mem_we_n,
   output logic                            mem_oe_n,
   output logic                            mem_rst_n,
   output logic                            mem_acc_hv,
   output logic      [mes_pkg::ADDR_W-1:0] mem_addr,
   input  wire logic [mes_pkg::DATA_W-1:0] mem_dq_i,
   output logic      [mes_pkg::DATA_W-1:0] mem_dq_o,
   output logic                            mem_dq_oe
);
   import mes_pkg::*;

   typedef enum logic [2:0] {H_IDLE, H_SEQ, H_POLL, H_RESET} mes_hstate_t;

   mes_hstate_t       st_q;
   logic [3:0]        cmd_q;
   logic [2:0]        step_q;
   logic [2:0]        nsteps_q;
   logic [ADDR_W-1:0] addr_q;
   logic [15:0]       wdata_q;
   logic [15:0]       rdata_q;
   logic [15:0]       prev_q;
   logic              acc_q;
   logic              hrst_q;
   logic              busy_q;
   logic              done_q;
   logic              fail_q;
   logic              ack_q;
   mes_cyc_t          cyc;
   mes_pins_t         pins;
   logic              cyc_done;
   logic [15:0]       cyc_rdata;
   logic              go_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wb_req  = wb_cyc_i && wb_stb_i && !ack_q;
   wire wr_ctrl = wb_req && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0];
   wire wr_addr = wb_req && wb_we_i && wb_adr_i == REG_ADDR;
   wire wr_data = wb_req && wb_we_i && wb_adr_i == REG_WDATA;
   wire new_cmd = wr_ctrl && !busy_q;
   wire [3:0] wcmd = wb_dat_i[CTRL_CMD_LSB +: 4];
   wire [31:0] status_w = {16'h0000, 13'h0000, fail_q, done_q, busy_q};
   wire [31:0] rd_mux = (wb_adr_i == REG_STATUS) ? status_w :
                        (wb_adr_i == REG_ADDR)   ? {10'h000, addr_q} :
                        (wb_adr_i == REG_WDATA)  ? {16'h0000, wdata_q} :
                        {16'h0000, rdata_q};

   ////////////////////////////////////////////////////////////////////////////
   // Sequence table: step index to address and data of each write
   wire        is_prog = (cmd_q == CMD_PROGRAM);
   wire        is_id   = (cmd_q == CMD_ID);
   wire        is_rd   = (cmd_q == CMD_READ);
   wire        is_rst  = (cmd_q == CMD_RESET);
   // Accelerated program skips unlock
   // Setup write stays: only the two unlock writes go
   wire [2:0]  base    = (is_prog && acc_q) ? 3'h2 : 3'h0;
   wire [2:0]  idx     = step_q + base;
   logic [15:0] seq_a;
   logic [7:0]  seq_d;
   always_comb begin
      seq_a = UNLOCK_A1;
      seq_d = UNLOCK_D1;
      unique case (idx)
         3'h0, 3'h3: begin
            seq_a = UNLOCK_A1;
            seq_d = UNLOCK_D1;
         end
         3'h1, 3'h4: begin
            seq_a = UNLOCK_A2;
            seq_d = UNLOCK_D2;
         end
         3'h2: begin
            seq_a = UNLOCK_A1;
            seq_d = (cmd_q == CMD_ERASE) ? CODE_ESET : is_id ? CODE_ID : CODE_PROG;
         end
         3'h5: begin
            seq_a = UNLOCK_A1;
            seq_d = CODE_ERAS;
         end
         default: begin
            seq_a = UNLOCK_A1;
            seq_d = UNLOCK_D1;
         end
      endcase
   end
   wire last_is_data = is_prog && (idx == 3'h3);
   // ID read at address 0 or 1 after the ID writes
   wire id_read = is_id && (step_q == 3'h3);
   wire seq_rd  = is_rd || id_read;
   always_comb begin
      cyc.rd   = seq_rd;
      cyc.addr = (seq_rd || last_is_data) ? addr_q : ADDR_W'(seq_a);
      cyc.data = is_rst ? {8'h00, CODE_RST} :
                 last_is_data ? wdata_q : {8'h00, seq_d};
      if (st_q == H_POLL) begin
         cyc.rd   = 1'b1;
         cyc.addr = addr_q;
         cyc.data = 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Toggle read by strobe
   // Toggle bit equal on two reads means finished
   wire toggling  = (cyc_rdata[TOGL_BIT] != prev_q[TOGL_BIT]);
   // Time-limit flag seen while still toggling
   // Two flagged reads needed: array data may carry bit 5 set
   wire tlim      = cyc_rdata[TLIM_BIT] && prev_q[TLIM_BIT] && toggling;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q     <= H_IDLE;
         cmd_q    <= 4'h0;
         step_q   <= 3'h0;
         nsteps_q <= 3'h0;
         addr_q   <= '0;
         wdata_q  <= 16'h0000;
         rdata_q  <= 16'h0000;
         prev_q   <= 16'h0000;
         acc_q    <= 1'b0;
         hrst_q   <= 1'b0;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         fail_q   <= 1'b0;
         go_q     <= 1'b0;
      end else begin
         go_q <= 1'b0;
         if (wr_addr) addr_q <= wb_dat_i[ADDR_W-1:0];
         if (wr_data) wdata_q <= wb_dat_i[15:0];
         if (wr_ctrl) begin
            acc_q <= wb_dat_i[CTRL_ACC_BIT];
            hrst_q <= wb_dat_i[CTRL_RST_BIT];
         end
         if (new_cmd && wcmd != 4'h0) begin
            cmd_q  <= wcmd;
            step_q <= 3'h0;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            go_q   <= 1'b1;
            st_q   <= H_SEQ;
            unique case (wcmd)
               CMD_ERASE:   nsteps_q <= 3'h6;
               CMD_PROGRAM: nsteps_q <= wb_dat_i[CTRL_ACC_BIT] ? 3'h2 : 3'h4;
               CMD_ID:      nsteps_q <= 3'h4;
               default:     nsteps_q <= 3'h1;
            endcase
         end else if (hrst_q && st_q != H_IDLE) begin
            st_q   <= H_IDLE;
            busy_q <= 1'b0;
            fail_q <= 1'b1;
         end
         unique case (st_q)
            H_IDLE: ;
            H_SEQ: begin
               if (cyc_done) begin
                  if (seq_rd) rdata_q <= cyc_rdata;
                  if (step_q + 3'h1 == nsteps_q) begin
                     // Status valid after last write strobe
                     if (cmd_q == CMD_ERASE || is_prog) begin
                        st_q <= H_POLL;
                        prev_q <= 16'h0000;
                        step_q <= 3'h0;
                        go_q   <= 1'b1;
                     end else begin
                        st_q   <= H_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                     end
                  end else begin
                     step_q <= step_q + 3'h1;
                     go_q   <= 1'b1;
                  end
               end
            end
            H_POLL: begin
               if (cyc_done) begin
                  prev_q  <= cyc_rdata;
                  rdata_q <= cyc_rdata;
                  step_q  <= 3'h1;
                  if (step_q != 3'h0 && !toggling) begin
                     st_q   <= H_IDLE;
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                  end else if (step_q != 3'h0 && tlim) begin
                     st_q   <= H_RESET;
                     cmd_q  <= CMD_RESET;
                     fail_q <= 1'b1;
                     go_q   <= 1'b1;
                  end else begin
                     go_q <= 1'b1;
                  end
               end
            end
            H_RESET: begin
               if (cyc_done) begin
                  // Failure left for software to judge
                  st_q   <= H_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_q    <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_q    <= wb_req;
         wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
      end
   end

   mes_bus_cycle u_cyc (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (go_q),
      .req     (cyc),
      .dq_i    (mem_dq_i),
      .pins    (pins),
      .done    (cyc_done),
      .rdata   (cyc_rdata)
   );

   assign wb_ack_o   = ack_q;
   assign mem_ce_n   = pins.ce_n;
   assign mem_we_n   = pins.we_n;
   assign mem_oe_n   = pins.oe_n;
   assign mem_addr   = pins.addr;
   assign mem_dq_o   = pins.dq_o;
   assign mem_dq_oe  = pins.dq_oe;
   assign mem_rst_n  = ~hrst_q;
   // High voltage only while an accelerated program is in flight
   assign mem_acc_hv = acc_q && is_prog && busy_q;
endmodule

// File: tb/mes_flash_model.sv
module mes_flash_model #(
   parameter logic [15:0] MAKER_ID  = 16'h0000,
   parameter logic [15:0] DEVICE_ID = 16'h0000,
   parameter int          PROG_CYC  = 20,
   parameter int          ERASE_CYC = 60,
   parameter bit          ALL_PROT  = 1'b0
) (
   input  wire logic                       clk,
   input  wire logic                       fail_en,
   input  wire logic                       ce_n,
   input  wire logic                       we_n,
   input  wire logic                       oe_n,
   input  wire logic                       rst_n,
   input  wire logic                       acc_hv,
   input  wire logic [mes_pkg::ADDR_W-1:0] addr,
   input  wire logic [mes_pkg::DATA_W-1:0] dq_o,
   output logic      [mes_pkg::DATA_W-1:0] dq_i
);
   timeunit 1ns;
   timeprecision 1ns;
   import mes_pkg::*;
   logic [15:0]       mem [int];
   logic [15:0]       lastq = 16'h0000;
   logic [15:0]       pdat = 16'h0000;
   logic [15:0]       val;
   logic              pwe = 1'b1, poe = 1'b1, busy = 1'b0, ers = 1'b0;
   logic              tog = 1'b0, tlim = 1'b0, idm = 1'b0;
   logic [ADDR_W-1:0] pa = '0;
   int                seq = 0, tmr = 0;
   wire               rd = !ce_n && !oe_n;
   wire               wr = !pwe && we_n;
   wire [7:0]         cd = dq_o[7:0];
   wire               u1 = addr[10:0] == UNLOCK_A1[10:0] && cd == UNLOCK_D1;
   wire               u2 = addr[10:0] == UNLOCK_A2[10:0] && cd == UNLOCK_D2;
   function automatic logic [15:0] look(input logic [ADDR_W-1:0] a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction
   ////////////////////////////////////////
   // read values
   assign val = busy ? {8'h00, !ers && addr == pa && !pdat[7], tog, tlim, 5'h00}
              : (idm && !addr[6] && !addr[1]) ? (addr[0] ? DEVICE_ID : MAKER_ID) : look(addr);
   // Released bus shows the inverse of the last word read, never the old word
   assign dq_i = rd ? val : ~lastq;
   always @(posedge clk) begin
      pwe <= we_n;
      poe <= oe_n;
      if (rd)
         lastq <= val;
      if (!rst_n) begin
         busy <= 0;
         seq <= 0;
         tlim <= 0;
         idm <= 0;
      end else if (busy) begin
         if (!poe && oe_n)
            tog <= !tog;
         if (tlim) begin
            if (wr && cd == CODE_RST)
               {busy, tlim} <= 2'b00;
         end else if (tmr == 0) begin
            busy <= 0;
            if (ers && !ALL_PROT)
               mem.delete();
         end else begin
            tmr <= tmr - 1;
            if (fail_en && tmr == 5)
               tlim <= 1;
         end
      end else if (wr) begin
         seq <= 0;
         if (cd == CODE_RST)
            idm <= 0;
         else case (seq)
            0: seq <= u1 ? 1 : (acc_hv && cd == CODE_PROG) ? 7 : 0;
            1: seq <= u2 ? 2 : 0;
            2: begin
               seq <= cd == CODE_ESET ? 3 : cd == CODE_PROG ? 7 : 0;
               if (cd == CODE_ID)
                  idm <= 1;
            end
            3: seq <= u1 ? 4 : 0;
            4: seq <= u2 ? 5 : 0;
            5: if (cd == CODE_ERAS) begin
               {busy, ers} <= 2'b11;
               tmr <= ERASE_CYC;
               foreach (mem[k])
                  mem[k] = 16'h0000;
            end
            default: begin
               {busy, ers} <= 2'b10;
               tmr <= PROG_CYC;
               pa <= addr;
               pdat <= dq_o;
               mem[addr] = look(addr) & dq_o;
            end
         endcase
      end
   end
endmodule

// File: tb/mes_host_chk.sv
module mes_host_chk (
   input wire logic                       sys_clk,
   input wire logic                       rst,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_ack_o,
   input wire logic                       mem_ce_n,
   input wire logic                       mem_we_n,
   input wire logic                       mem_oe_n,
   input wire logic [mes_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [mes_pkg::DATA_W-1:0] mem_dq_o,
   input wire logic                       mem_dq_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence wr_pulse;
      !mem_we_n [*3] ##1 mem_we_n;
   endsequence
   sequence rd_pulse;
      !mem_oe_n [*3] ##1 mem_oe_n;
   endsequence
   sequence all_idle;
      (mem_ce_n && mem_we_n && mem_oe_n) [*3];
   endsequence
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   write_width_a: assert property ($fell(mem_we_n) |-> wr_pulse)
      else $error("write strobe width wrong");
   read_width_a: assert property ($fell(mem_oe_n) |-> rd_pulse)
      else $error("read strobe width wrong");
   write_setup_a: assert property ($fell(mem_we_n) |-> $past(mem_ce_n, 3) == 1'b0)
      else $error("select setup short");
   write_hold_a: assert property (!mem_we_n |-> !mem_ce_n && mem_dq_oe
      && $stable(mem_addr) && $stable(mem_dq_o))
      else $error("write cycle unstable");
   strobe_excl_a: assert property (!mem_we_n |-> mem_oe_n)
      else $error("both strobes low");
   read_drive_a: assert property (!mem_oe_n |-> !mem_dq_oe && !mem_ce_n)
      else $error("read with bus driven");
   strobe_idle_a: assert property ($rose(mem_we_n) || $rose(mem_oe_n) |-> all_idle)
      else $error("no idle after strobe");
endmodule
bind mes_host mes_host_chk chk_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
   .mem_oe_n(mem_oe_n), .mem_addr(mem_addr), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));

// File: tb/test_mes_host.sv
module test_mes_host;
   timeunit 1ns;
   timeprecision 1ns;
   import mes_pkg::*;
   // Identity values are arbitrary
   localparam logic [15:0] MAKER_ID  = 16'h00a5;
   localparam logic [15:0] DEVICE_ID = 16'h5a3c;
   logic              sys_clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, fail_en = 0;
   logic [3:0]        adr = 4'h0;
   logic [31:0]       dat = 32'h0, rdat, r, st;
   logic              ack, ce_n, we_n, oe_n, rst_n, acc, dq_oe;
   logic [ADDR_W-1:0] maddr, a, a0;
   logic [DATA_W-1:0] dq_i, dq_o, d, ev;
   int                failures = 0, checks = 0;
   int                exp_mem[int];
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
   always #20 sys_clk = ~sys_clk;
   mes_host mes_host_i (.sys_clk(sys_clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .mem_ce_n(ce_n), .mem_we_n(we_n), .mem_oe_n(oe_n), .mem_rst_n(rst_n),
      .mem_acc_hv(acc), .mem_addr(maddr), .mem_dq_i(dq_i), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe));
   mes_flash_model #(.MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) mes_flash_model_i (
      .clk(sys_clk), .fail_en(fail_en), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .rst_n(rst_n), .acc_hv(acc), .addr(maddr), .dq_o(dq_o), .dq_i(dq_i));
   ////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic hang();
      failures++;
      $display("[FAIL] wait exp done got still waiting");
      complete_run();
   endtask
   // One classic cycle: hold until ack is sampled, then release
   task automatic wb(input logic [3:0] wa, input logic [31:0] wd, input logic ww,
                     output logic [31:0] wr);
      int n;
      n = 0;
      adr <= wa;
      dat <= wd;
      we <= ww;
      {cyc, stb} <= 2'b11;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      wr = rdat;
      {cyc, stb, we} <= 3'b000;
      @(posedge sys_clk);
      if (n >= 20)
         hang();
   endtask
   task automatic run(input logic [3:0] cmd, input logic [1:0] ctl,
                      input logic [ADDR_W-1:0] ra, input logic [DATA_W-1:0] rd);
      int n;
      n = 0;
      wb(REG_ADDR, 32'(ra), 1'b1, r);
      wb(REG_WDATA, 32'(rd), 1'b1, r);
      wb(REG_CTRL, {26'h0, ctl, cmd}, 1'b1, r);
      do begin
         wb(REG_STATUS, 32'h0, 1'b0, st);
         n++;
      end while (st[ST_BUSY] !== 1'b0 && n < 300);
      if (n >= 300)
         hang();
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] ra, input logic [DATA_W-1:0] e);
      run(CMD_READ, 2'b00, ra, 16'h0000);
      wb(REG_RDATA, 32'h0, 1'b0, r);
      `CHK("rdata", e, r[15:0])
   endtask
   initial begin
      logic [31:0] t;
      void'($urandom(32'h5218));
      repeat (16) @(posedge sys_clk);
      rst <= 0;
      wb(REG_STATUS, 32'h0, 1'b0, st);
      `CHK("idle busy", 1'b0, st[ST_BUSY])
      // Last pass reprograms the first word: bits only clear
      for (int i = 0; i < 4; i++) begin
         t = $urandom;
         a = (i == 3) ? a0 : t[ADDR_W-1:0];
         if (i == 0)
            a0 = a;
         t = $urandom;
         d = t[DATA_W-1:0];
         run(CMD_PROGRAM, {1'b0, i[0]}, a, d);
         `CHK("prog fail", 1'b0, st[ST_FAIL])
         ev = exp_mem.exists(a) ? 16'(exp_mem[a]) : 16'hffff;
         exp_mem[a] = int'(ev & d);
         rd_chk(a, ev & d);
      end
      run(CMD_ID, 2'b00, 22'h0, 16'h0);
      wb(REG_RDATA, 32'h0, 1'b0, r);
      `CHK("maker", MAKER_ID, r[15:0])
      run(CMD_ID, 2'b00, 22'h1, 16'h0);
      wb(REG_RDATA, 32'h0, 1'b0, r);
      `CHK("device", DEVICE_ID, r[15:0])
      run(CMD_RESET, 2'b00, 22'h0, 16'h0);
      rd_chk(a0, 16'(exp_mem[a0]));
      run(CMD_ERASE, 2'b00, a0, 16'h0);
      `CHK("erase fail", 1'b0, st[ST_FAIL])
      exp_mem.delete();
      rd_chk(a0, 16'hffff);
      fail_en <= 1;
      run(CMD_ERASE, 2'b00, a0, 16'h0);
      `CHK("limit fail", 1'b1, st[ST_FAIL])
      fail_en <= 0;
      rd_chk(a, 16'hffff);
      wb(REG_CTRL, 32'(CMD_ERASE), 1'b1, r);
      repeat (22) wb(REG_STATUS, 32'h0, 1'b0, st);
      `CHK("erase busy", 1'b1, st[ST_BUSY])
      wb(REG_CTRL, 32'h20, 1'b1, r);
      run(4'h0, 2'b00, a, 16'h0);
      `CHK("abort fail", 1'b1, st[ST_FAIL])
      rd_chk(a, 16'hffff);
      wb(4'h6, 32'h0, 1'b0, r);
      `CHK("unmapped", 16'hffff, r[15:0])
      complete_run();
   end
endmodule
